// ### core/cie_defines.svh
// Constants for the instruction execute subset
`ifndef CIE_DEFINES_SVH
`define CIE_DEFINES_SVH
`define CIE_OP_INCREMENT_FILE     6'b0010_10
`define CIE_OP_INCREMENT_SKIP_ZERO   6'b0011_11
`define CIE_OP_OR_ACC_WITH_FILE    6'b0001_00
`define CIE_OP_MOVE_FILE     6'b0010_00
`define CIE_OP_RLF      6'b0011_01
`define CIE_OP_RRF      6'b0011_00
`define CIE_OP_OR_LITERAL_INTO_ACC    4'b1101
`define CIE_OP_LOAD_LITERAL_ACC    4'b1100
`define CIE_OP_BRANCH_ABSOLUTE     3'b101
`define CIE_OP_SLEEP    12'h003
`define CIE_NOP_WORD    12'h000
`define CIE_ST_CARRY    0
`define CIE_ST_ZERO     2
`define CIE_ST_PD_N     3
`define CIE_ST_TO_N     4
`define CIE_ST_PAGE_LO  5
`define CIE_ST_PAGE_HI  6
`define CIE_ST_RESET    8'h18
`define CIE_PC_RESET    11'h7ff
`define CIE_ZERO8       8'h00
`define CIE_ONE8        8'h01
`endif

// ### core/cie_pkg.sv
// Types for the instruction execute subset
package cie_pkg;
  typedef enum logic [3:0] {
    CIE_NOP     = 4'b0000,
    CIE_INCREMENT_FILE    = 4'b0001,
    CIE_INCREMENT_SKIP_ZERO  = 4'b0010,
    CIE_OR_LITERAL_INTO_ACC   = 4'b0011,
    CIE_OR_ACC_WITH_FILE   = 4'b0100,
    CIE_MOVE_FILE    = 4'b0101,
    CIE_LOAD_LITERAL_ACC   = 4'b0110,
    CIE_RLF     = 4'b0111,
    CIE_RRF     = 4'b1000,
    CIE_BRANCH_ABSOLUTE    = 4'b1001,
    CIE_SLEEP   = 4'b1010,
    CIE_OTHER   = 4'b1011
  } cie_op_t;

  typedef enum logic [1:0] {
    CIE_RUN   = 2'b00,
    CIE_FLUSH = 2'b01,
    CIE_SLEPT = 2'b10
  } cie_state_t;
endpackage : cie_pkg

// ### core/cie_dec_if.sv
// Decoded instruction fields shared between decoder and core
`timescale 1ns/1ps
interface cie_dec_if;
  cie_pkg::cie_op_t op;
  logic [4:0]       faddr;
  logic             dest;
  logic [7:0]       lit8;
  logic [8:0]       lit9;
  modport dec  (output op, output faddr, output dest, output lit8, output lit9);
  modport core (input op, input faddr, input dest, input lit8, input lit9);
endinterface : cie_dec_if

// ### core/cie_decoder.sv
// Combinational decoder of the 12-bit instruction word
`timescale 1ns/1ps
`include "cie_defines.svh"
module cie_decoder (
  input  wire logic [11:0] instr,
  cie_dec_if.dec           dec
);
  // Field extraction
  assign dec.faddr = instr[4:0];
  assign dec.dest  = instr[5];
  assign dec.lit8  = instr[7:0];
  assign dec.lit9  = instr[8:0];

  // Opcode classification
  always_comb
  begin
    dec.op = cie_pkg::CIE_OTHER;
    if (instr == `CIE_NOP_WORD)
      dec.op = cie_pkg::CIE_NOP;
    else if (instr == `CIE_OP_SLEEP)
      dec.op = cie_pkg::CIE_SLEEP;
    else if (instr[11:9] == `CIE_OP_BRANCH_ABSOLUTE)
      dec.op = cie_pkg::CIE_BRANCH_ABSOLUTE;
    else if (instr[11:8] == `CIE_OP_OR_LITERAL_INTO_ACC)
      dec.op = cie_pkg::CIE_OR_LITERAL_INTO_ACC;
    else if (instr[11:8] == `CIE_OP_LOAD_LITERAL_ACC)
      dec.op = cie_pkg::CIE_LOAD_LITERAL_ACC;
    else if (instr[11:6] == `CIE_OP_INCREMENT_FILE)
      dec.op = cie_pkg::CIE_INCREMENT_FILE;
    else if (instr[11:6] == `CIE_OP_INCREMENT_SKIP_ZERO)
      dec.op = cie_pkg::CIE_INCREMENT_SKIP_ZERO;
    else if (instr[11:6] == `CIE_OP_OR_ACC_WITH_FILE)
      dec.op = cie_pkg::CIE_OR_ACC_WITH_FILE;
    else if (instr[11:6] == `CIE_OP_MOVE_FILE)
      dec.op = cie_pkg::CIE_MOVE_FILE;
    else if (instr[11:6] == `CIE_OP_RLF)
      dec.op = cie_pkg::CIE_RLF;
    else if (instr[11:6] == `CIE_OP_RRF)
      dec.op = cie_pkg::CIE_RRF;
  end
endmodule : cie_decoder

// ### core/cie_alu.sv
// Arithmetic and logic for the subset
`timescale 1ns/1ps
`include "cie_defines.svh"
module cie_alu (
  cie_dec_if.core          dec,
  input  wire logic [7:0]  acc,
  input  wire logic [7:0]  fdata,
  input  wire logic        carry_in,
  output logic      [7:0]  result,
  output logic             carry_out,
  output logic             zero_upd,
  output logic             carry_upd,
  output logic             writes
);
  // Result and flag selection per opcode
  always_comb
  begin
    result    = fdata;
    carry_out = carry_in;
    zero_upd  = 1'b0;
    carry_upd = 1'b0;
    writes    = 1'b1;
    unique case (dec.op)
      cie_pkg::CIE_INCREMENT_FILE:
      begin
        result   = fdata + `CIE_ONE8;
        zero_upd = 1'b1;
      end
      cie_pkg::CIE_INCREMENT_SKIP_ZERO: result = fdata + `CIE_ONE8;
      cie_pkg::CIE_OR_LITERAL_INTO_ACC:
      begin
        result   = acc | dec.lit8;
        zero_upd = 1'b1;
      end
      cie_pkg::CIE_OR_ACC_WITH_FILE:
      begin
        result   = acc | fdata;
        zero_upd = 1'b1;
      end
      cie_pkg::CIE_MOVE_FILE: zero_upd = 1'b1;
      cie_pkg::CIE_LOAD_LITERAL_ACC: result = dec.lit8;
      cie_pkg::CIE_RLF:
      begin
        result    = {fdata[6:0], carry_in};
        carry_out = fdata[7];
        carry_upd = 1'b1;
      end
      cie_pkg::CIE_RRF:
      begin
        result    = {carry_in, fdata[7:1]};
        carry_out = fdata[0];
        carry_upd = 1'b1;
      end
      default: writes = 1'b0;
    endcase
  end
endmodule : cie_alu

// ### core/cie_core.sv
// Execute stage for the instruction subset
`timescale 1ns/1ps
`include "cie_defines.svh"
module cie_core #(
  parameter int PC_W = 11
) (
  input  wire logic            ref_clk,
  input  wire logic            rst,
  input  wire logic [11:0]     instr,
  input  wire logic            instr_valid,
  input  wire logic [7:0]      fdata,
  input  wire logic            presc_to_wdt,
  input  wire logic            wake,
  output logic      [4:0]      faddr,
  output logic      [7:0]      fwdata,
  output logic                 fwe,
  output logic      [PC_W-1:0] pc,
  output logic                 pc_load,
  output logic                 flush,
  output logic      [7:0]      acc,
  output logic      [7:0]      status,
  output logic                 sleep_mode,
  output logic                 osc_stop,
  output logic                 wdt_clear,
  output logic                 presc_clear
);
  cie_dec_if dif ();
  logic [7:0] result;
  logic       carry_out;
  logic       zero_upd;
  logic       carry_upd;
  logic       writes;
  logic       exec;
  logic [7:0] acc_reg, acc_next;
  logic [7:0] st_reg, st_next;
  logic [PC_W-1:0] pc_reg, pc_next;
  logic       fwe_reg, fwe_next;
  logic [7:0] fwd_reg, fwd_next;
  logic       ld_reg, ld_next;
  logic       clr_reg, clr_next;
  logic       pclr_reg, pclr_next;
  cie_pkg::cie_state_t st_q, st_d;

  cie_decoder u_dec (
    .instr (instr),
    .dec   (dif)
  );

  cie_alu u_alu (
    .dec       (dif),
    .acc       (acc_reg),
    .fdata     (fdata),
    .carry_in  (st_reg[`CIE_ST_CARRY]),
    .result    (result),
    .carry_out (carry_out),
    .zero_upd  (zero_upd),
    .carry_upd (carry_upd),
    .writes    (writes)
  );

  // Only execute in run state with a valid word
  assign exec  = instr_valid && (st_q == cie_pkg::CIE_RUN);
  assign faddr = dif.faddr;
  assign flush = (st_q == cie_pkg::CIE_FLUSH);

  // Next state of the execute stage
  always_comb
  begin
    acc_next  = acc_reg;
    st_next   = st_reg;
    pc_next   = pc_reg;
    fwe_next  = 1'b0;
    fwd_next  = fwd_reg;
    ld_next   = 1'b0;
    clr_next  = 1'b0;
    pclr_next = 1'b0;
    st_d      = st_q;
    unique case (st_q)
      cie_pkg::CIE_RUN:
      begin
        if (exec)
        begin
          pc_next = pc_reg + 1'b1;
          if (writes)
          begin
            if (dif.dest && dif.op != cie_pkg::CIE_OR_LITERAL_INTO_ACC && dif.op != cie_pkg::CIE_LOAD_LITERAL_ACC)
            begin
              fwe_next = 1'b1;
              fwd_next = result;
            end
            else
              acc_next = result;
            if (zero_upd)
              st_next[`CIE_ST_ZERO] = (result == `CIE_ZERO8);
            if (carry_upd)
              st_next[`CIE_ST_CARRY] = carry_out;
          end
          if (dif.op == cie_pkg::CIE_INCREMENT_SKIP_ZERO && result == `CIE_ZERO8)
            st_d = cie_pkg::CIE_FLUSH;
          if (dif.op == cie_pkg::CIE_BRANCH_ABSOLUTE)
          begin
            pc_next = PC_W'({st_reg[`CIE_ST_PAGE_HI], st_reg[`CIE_ST_PAGE_LO], dif.lit9});
            ld_next = 1'b1;
            st_d    = cie_pkg::CIE_FLUSH;
          end
          if (dif.op == cie_pkg::CIE_SLEEP)
          begin
            st_next[`CIE_ST_TO_N] = 1'b1;
            st_next[`CIE_ST_PD_N] = 1'b0;
            clr_next  = 1'b1;
            pclr_next = presc_to_wdt;
            st_d      = cie_pkg::CIE_SLEPT;
          end
        end
      end
      // Discarded word runs as no-op
      cie_pkg::CIE_FLUSH:
      begin
        if (instr_valid)
        begin
          pc_next = pc_reg + 1'b1;
          st_d    = cie_pkg::CIE_RUN;
        end
      end
      cie_pkg::CIE_SLEPT:
      begin
        if (wake)
          st_d = cie_pkg::CIE_RUN;
      end
      default: st_d = cie_pkg::CIE_RUN;
    endcase
  end

  // State registers
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      acc_reg  <= `CIE_ZERO8;
      st_reg   <= `CIE_ST_RESET;
      pc_reg   <= PC_W'(`CIE_PC_RESET);
      fwe_reg  <= 1'b0;
      fwd_reg  <= `CIE_ZERO8;
      ld_reg   <= 1'b0;
      clr_reg  <= 1'b0;
      pclr_reg <= 1'b0;
      st_q     <= cie_pkg::CIE_RUN;
    end
    else
    begin
      acc_reg  <= acc_next;
      st_reg   <= st_next;
      pc_reg   <= pc_next;
      fwe_reg  <= fwe_next;
      fwd_reg  <= fwd_next;
      ld_reg   <= ld_next;
      clr_reg  <= clr_next;
      pclr_reg <= pclr_next;
      st_q     <= st_d;
    end
  end

  // Outputs from registers
  assign acc         = acc_reg;
  assign status      = st_reg;
  assign pc          = pc_reg;
  assign pc_load     = ld_reg;
  assign fwe         = fwe_reg;
  assign fwdata      = fwd_reg;
  assign sleep_mode  = (st_q == cie_pkg::CIE_SLEPT);
  assign osc_stop    = (st_q == cie_pkg::CIE_SLEPT);
  assign wdt_clear   = clr_reg;
  assign presc_clear = pclr_reg;

  // Assertions
  sequence s_skip_taken;
    exec && dif.op == cie_pkg::CIE_INCREMENT_SKIP_ZERO && fdata == 8'hff;
  endsequence
  sequence s_branch_issue;
    exec && dif.op == cie_pkg::CIE_BRANCH_ABSOLUTE;
  endsequence
  sequence s_discard_slot;
    flush && instr_valid;
  endsequence

  a_inc_zero_flag: assert property (@(posedge ref_clk) disable iff (rst)
    exec && dif.op == cie_pkg::CIE_INCREMENT_FILE |=> status[`CIE_ST_ZERO] == ($past(fdata) == 8'hff))
    else $error("increment zero flag wrong");
  a_inc_file: assert property (@(posedge ref_clk) disable iff (rst)
    exec && dif.op == cie_pkg::CIE_INCREMENT_FILE && dif.dest |=> fwe && fwdata == 8'($past(fdata) + `CIE_ONE8))
    else $error("increment into file wrong");
  a_inc_acc: assert property (@(posedge ref_clk) disable iff (rst)
    exec && dif.op == cie_pkg::CIE_INCREMENT_FILE && !dif.dest |=> !fwe && acc == 8'($past(fdata) + `CIE_ONE8))
    else $error("increment into accumulator wrong");

  a_skip_flags_kept: assert property (@(posedge ref_clk) disable iff (rst)
    exec && dif.op == cie_pkg::CIE_INCREMENT_SKIP_ZERO |=> status == $past(status))
    else $error("skip increment changed flags");
  a_skip_result: assert property (@(posedge ref_clk) disable iff (rst)
    exec && dif.op == cie_pkg::CIE_INCREMENT_SKIP_ZERO && dif.dest |=> fwe && fwdata == 8'($past(fdata) + `CIE_ONE8))
    else $error("skip increment result wrong");

  a_skip_flush: assert property (@(posedge ref_clk) disable iff (rst)
    s_skip_taken |=> flush && fwe == $past(dif.dest))
    else $error("skip did not flush");
  a_skip_not_taken: assert property (@(posedge ref_clk) disable iff (rst)
    exec && dif.op == cie_pkg::CIE_INCREMENT_SKIP_ZERO && fdata != 8'hff |=> !flush)
    else $error("skip flushed without zero result");
  a_discard_slot: assert property (@(posedge ref_clk) disable iff (rst)
    s_discard_slot |=> !flush && !fwe && acc == $past(acc) && status == $past(status)
      && pc == PC_W'($past(pc) + 1'b1))
    else $error("discarded word was not a no-op");

  a_orlit_acc: assert property (@(posedge ref_clk) disable iff (rst)
    exec && dif.op == cie_pkg::CIE_OR_LITERAL_INTO_ACC |=> acc == ($past(acc) | $past(instr[7:0])))
    else $error("literal or wrong");
  a_orlit_zero: assert property (@(posedge ref_clk) disable iff (rst)
    exec && dif.op == cie_pkg::CIE_OR_LITERAL_INTO_ACC
      |=> status[`CIE_ST_ZERO] == (($past(acc) | $past(instr[7:0])) == `CIE_ZERO8))
    else $error("literal or zero flag wrong");

  a_orfile_dest: assert property (@(posedge ref_clk) disable iff (rst)
    exec && dif.op == cie_pkg::CIE_OR_ACC_WITH_FILE && dif.dest |=> fwe && fwdata == ($past(acc) | $past(fdata)))
    else $error("file or wrong");
  a_orfile_acc: assert property (@(posedge ref_clk) disable iff (rst)
    exec && dif.op == cie_pkg::CIE_OR_ACC_WITH_FILE && !dif.dest |=> !fwe && acc == ($past(acc) | $past(fdata)))
    else $error("file or to accumulator wrong");

  a_move_acc: assert property (@(posedge ref_clk) disable iff (rst)
    exec && dif.op == cie_pkg::CIE_MOVE_FILE && !dif.dest |=> acc == $past(fdata) && !fwe)
    else $error("move to acc wrong");
  a_move_test: assert property (@(posedge ref_clk) disable iff (rst)
    exec && dif.op == cie_pkg::CIE_MOVE_FILE && dif.dest |=> fwe && fwdata == $past(fdata)
      && status[`CIE_ST_ZERO] == ($past(fdata) == `CIE_ZERO8))
    else $error("file test wrong");

  a_rlf_carry: assert property (@(posedge ref_clk) disable iff (rst)
    exec && dif.op == cie_pkg::CIE_RLF |=> status[`CIE_ST_CARRY] == $past(fdata[7]))
    else $error("rotate left carry wrong");
  a_rlf_result: assert property (@(posedge ref_clk) disable iff (rst)
    exec && dif.op == cie_pkg::CIE_RLF && !dif.dest
      |=> acc == {$past(fdata[6:0]), $past(status[`CIE_ST_CARRY])})
    else $error("rotate left result wrong");

  a_rrf_carry: assert property (@(posedge ref_clk) disable iff (rst)
    exec && dif.op == cie_pkg::CIE_RRF |=> status[`CIE_ST_CARRY] == $past(fdata[0]))
    else $error("rotate right carry wrong");
  a_rrf_result: assert property (@(posedge ref_clk) disable iff (rst)
    exec && dif.op == cie_pkg::CIE_RRF && dif.dest
      |=> fwe && fwdata == {$past(status[`CIE_ST_CARRY]), $past(fdata[7:1])})
    else $error("rotate right result wrong");
  a_rrf_only_carry: assert property (@(posedge ref_clk) disable iff (rst)
    exec && dif.op == cie_pkg::CIE_RRF |=> ((status ^ $past(status)) & ~`CIE_ONE8) == `CIE_ZERO8)
    else $error("rotate right changed other flags");

  a_sleep_enter: assert property (@(posedge ref_clk) disable iff (rst)
    exec && dif.op == cie_pkg::CIE_SLEEP |=> sleep_mode && osc_stop)
    else $error("sleep not entered");
  a_sleep_hold: assert property (@(posedge ref_clk) disable iff (rst)
    sleep_mode && !wake |=> sleep_mode && osc_stop && pc == $past(pc))
    else $error("sleep left without wake");

  a_sleep_wdt: assert property (@(posedge ref_clk) disable iff (rst)
    exec && dif.op == cie_pkg::CIE_SLEEP |=> wdt_clear && presc_clear == $past(presc_to_wdt))
    else $error("watchdog not cleared");
  a_clear_pulse: assert property (@(posedge ref_clk) disable iff (rst)
    wdt_clear |=> !wdt_clear && !presc_clear)
    else $error("watchdog clear too long");

  a_sleep_status: assert property (@(posedge ref_clk) disable iff (rst)
    exec && dif.op == cie_pkg::CIE_SLEEP |=> status[`CIE_ST_TO_N] && !status[`CIE_ST_PD_N])
    else $error("sleep status wrong");
  a_sleep_others: assert property (@(posedge ref_clk) disable iff (rst)
    exec && dif.op == cie_pkg::CIE_SLEEP |=> acc == $past(acc)
      && status[`CIE_ST_ZERO] == $past(status[`CIE_ST_ZERO])
      && status[`CIE_ST_CARRY] == $past(status[`CIE_ST_CARRY]))
    else $error("sleep changed other flags");

  a_branch_pc: assert property (@(posedge ref_clk) disable iff (rst)
    exec && dif.op == cie_pkg::CIE_BRANCH_ABSOLUTE |=> pc_load && flush && pc[8:0] == $past(instr[8:0]))
    else $error("branch target wrong");
  a_branch_page: assert property (@(posedge ref_clk) disable iff (rst)
    s_branch_issue
      |=> pc == PC_W'({$past(status[`CIE_ST_PAGE_HI]), $past(status[`CIE_ST_PAGE_LO]), $past(instr[8:0])}))
    else $error("branch page wrong");
  a_branch_two: assert property (@(posedge ref_clk) disable iff (rst)
    s_branch_issue ##1 s_discard_slot |=> !pc_load && !flush && acc == $past(acc))
    else $error("branch second cycle wrong");

  a_load_literal_acc_acc: assert property (@(posedge ref_clk) disable iff (rst)
    exec && dif.op == cie_pkg::CIE_LOAD_LITERAL_ACC |=> acc == $past(instr[7:0]) && status == $past(status))
    else $error("literal load wrong");
  a_load_literal_acc_file: assert property (@(posedge ref_clk) disable iff (rst)
    exec && dif.op == cie_pkg::CIE_LOAD_LITERAL_ACC |=> !fwe && !flush)
    else $error("literal load touched file");
endmodule : cie_core

// ### tb/cie_file_model.sv
// Register file model that stands on the far side of the execute core
`timescale 1ns/1ps
module cie_file_model (
  input  wire logic       ref_clk,
  input  wire logic [4:0] faddr,
  input  wire logic       fwe,
  input  wire logic [7:0] fwdata,
  output logic      [7:0] fdata
);
  logic [7:0] mem [32];
  logic [4:0] waddr_reg;

  // Known start pattern, mirrored by the bench
  initial
  begin
    for (int i = 0; i < 32; i++)
      mem[i] = 8'(i * 37 + 7);
  end

  // Write lands one edge late, at the executing word's address
  always @(posedge ref_clk)
  begin
    waddr_reg <= faddr;
    if (fwe)
      mem[waddr_reg] <= fwdata;
  end

  // Read is combinational
  assign fdata = mem[faddr];
endmodule : cie_file_model

// ### tb/cie_core_tb.sv
// Self-checking bench for the execute core against a reference model
`timescale 1ns/1ps
`include "cie_defines.svh"
module cie_core_tb;
  logic        ref_clk, rst, instr_valid, presc_to_wdt, wake;
  logic [11:0] instr;
  logic [7:0]  fdata, fwdata, acc, status;
  logic [4:0]  faddr;
  logic        fwe, pc_load, flush, sleep_mode, osc_stop, wdt_clear, presc_clear;
  logic [10:0] pc;
  int          error_cnt, checks_done;
  logic [31:0] seed;
  logic [7:0]  acc_m, st_m;
  logic [7:0]  mem_m [32];
  logic        asleep;
  logic [10:0] pc_m;
  logic [11:0] ops [10] = '{12'h280, 12'h3C0, 12'hD00, 12'h100, 12'h200, 12'hC00, 12'h340, 12'h300, 12'hA00, 12'h003};
  logic [11:0] msk [10] = '{12'h03F, 12'h03F, 12'h0FF, 12'h03F, 12'h03F, 12'h0FF, 12'h03F, 12'h03F, 12'h1FF, 12'h000};

  cie_core #(.PC_W(11)) cie_core_inst (.ref_clk(ref_clk), .rst(rst), .instr(instr), .instr_valid(instr_valid),
    .fdata(fdata), .presc_to_wdt(presc_to_wdt), .wake(wake), .faddr(faddr), .fwdata(fwdata), .fwe(fwe), .pc(pc),
    .pc_load(pc_load), .flush(flush), .acc(acc), .status(status), .sleep_mode(sleep_mode), .osc_stop(osc_stop),
    .wdt_clear(wdt_clear), .presc_clear(presc_clear));
  cie_file_model cie_file_model_inst (.ref_clk(ref_clk), .faddr(faddr), .fwe(fwe), .fwdata(fwdata), .fdata(fdata));

  // 20 MHz clock
  initial
  begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction : xs

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic test_done;
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : test_done

  // Run one word through model and design; disc offers a word in the cycle after
  task automatic exec(input logic [11:0] w, input logic disc);
    logic [7:0] f, r;
    logic       wr, la, z, sk, br, slp;
    f = mem_m[w[4:0]];
    r = acc_m;
    {wr, la, z, sk, br, slp} = 6'h00;
    if (!asleep)
    begin
      if (w[11:6] == `CIE_OP_INCREMENT_FILE) {r, wr, z} = {f + 8'h01, 2'b11};
      else if (w[11:6] == `CIE_OP_INCREMENT_SKIP_ZERO) {r, wr, sk} = {f + 8'h01, 1'b1, f == 8'hFF};
      else if (w[11:6] == `CIE_OP_OR_ACC_WITH_FILE) {r, wr, z} = {acc_m | f, 2'b11};
      else if (w[11:6] == `CIE_OP_MOVE_FILE) {r, wr, z} = {f, 2'b11};
      else if (w[11:6] == `CIE_OP_RLF) {r, wr, st_m[0]} = {f[6:0], st_m[0], 1'b1, f[7]};
      else if (w[11:6] == `CIE_OP_RRF) {r, wr, st_m[0]} = {st_m[0], f[7:1], 1'b1, f[0]};
      else if (w[11:8] == `CIE_OP_OR_LITERAL_INTO_ACC) {r, la, z} = {acc_m | w[7:0], 2'b11};
      else if (w[11:8] == `CIE_OP_LOAD_LITERAL_ACC) {r, la} = {w[7:0], 1'b1};
      else if (w[11:9] == `CIE_OP_BRANCH_ABSOLUTE) br = 1'b1;
      else if (w == `CIE_OP_SLEEP) {slp, asleep, st_m[`CIE_ST_TO_N], st_m[`CIE_ST_PD_N]} = 4'b1110;
      if (z)
        st_m[`CIE_ST_ZERO] = (r == 8'h00);
      if (la || (wr && !w[5]))
        acc_m = r;
      if (wr && w[5])
        mem_m[w[4:0]] = r;
      pc_m = br ? {st_m[6:5], w[8:0]} : pc_m + 11'h001;
    end
    @(negedge ref_clk);
    instr       <= w;
    instr_valid <= 1'b1;
    @(negedge ref_clk);
    chk(16'(acc), 16'(acc_m));
    chk(16'(status), 16'(st_m));
    chk(16'(faddr), 16'(w[4:0]));
    chk(16'(fwe), 16'(wr && w[5]));
    if (wr && w[5])
      chk(16'(fwdata), 16'(r));
    chk(16'(flush), 16'(sk || br));
    chk(16'(pc_load), 16'(br));
    if (br)
      chk(16'(pc), 16'({st_m[6:5], w[8:0]}));
    chk(16'(pc), 16'(pc_m));
    chk(16'({sleep_mode, osc_stop}), 16'({asleep, asleep}));
    chk(16'({wdt_clear, presc_clear}), 16'({slp, slp && presc_to_wdt}));
    // A taken skip or branch always gets its discard word
    if (disc || sk || br)
    begin
      instr <= 12'hC5A;
      @(negedge ref_clk);
      if (!asleep)
      begin
        if (!(sk || br))
          acc_m = 8'h5A;
        pc_m = pc_m + 11'h001;
      end
      chk(16'(acc), 16'(acc_m));
      chk(16'(pc), 16'(pc_m));
    end
    instr_valid <= 1'b0;
  endtask : exec

  // Main sequence: reset, skip and branch cases, then random words
  initial
  begin
    {rst, instr, instr_valid, presc_to_wdt, wake} = {1'b1, 12'h000, 3'b000};
    {seed, error_cnt, checks_done} = {32'h0000_0011, 64'h0};
    {acc_m, st_m, asleep} = {8'h00, `CIE_ST_RESET, 1'b0};
    pc_m = `CIE_PC_RESET;
    for (int i = 0; i < 32; i++)
      mem_m[i] = 8'(i * 37 + 7);
    repeat (16) @(posedge ref_clk);
    @(negedge ref_clk);
    rst = 1'b0;
    chk(16'({acc, status}), 16'({8'h00, `CIE_ST_RESET}));
    chk(16'(pc), 16'(`CIE_PC_RESET));
    exec(12'hDFF, 1'b0);
    exec(12'h123, 1'b0);
    exec(12'h3C3, 1'b1);
    exec(12'h3E3, 1'b1);
    exec(12'h223, 1'b0);
    exec(12'hA55, 1'b1);
    for (int n = 0; n < 400; n++)
    begin
      seed = xs(seed);
      presc_to_wdt <= seed[31];
      exec(ops[seed[3:0] % 10] | (seed[19:8] & msk[seed[3:0] % 10]), 1'b0);
      if (asleep)
      begin
        exec(12'hC5A, 1'b0);
        @(negedge ref_clk);
        wake <= 1'b1;
        @(negedge ref_clk);
        wake   <= 1'b0;
        asleep = 1'b0;
        chk(16'({sleep_mode, osc_stop}), 16'h0000);
      end
    end
    // Second reset in mid-run, after the last write has landed
    @(negedge ref_clk);
    rst = 1'b1;
    @(negedge ref_clk);
    rst = 1'b0;
    {acc_m, st_m, pc_m} = {8'h00, `CIE_ST_RESET, `CIE_PC_RESET};
    chk(16'({acc, status}), 16'({acc_m, st_m}));
    chk(16'(pc), 16'(pc_m));
    exec(12'hC7E, 1'b0);
    test_done();
  end

  // Cuts a hang short
  initial
  begin
    repeat (100000) @(posedge ref_clk);
    error_cnt++;
    test_done();
  end
endmodule : cie_core_tb
